// ==== core/gctm_pkg.sv ====
// Purpose: Shared constants and types for the counter/timer channel
// Assumes: 20 MHz system clock, one channel
// Notes: Mode, gate and edge codes are chosen for this block
package gctm_pkg;
  localparam int GCTM_W = 32;
  localparam int GCTM_DUTY_W = 7;
  localparam logic [31:0] GCTM_CNT_RST = 32'h0000_0000;
  localparam logic [31:0] GCTM_DIV_RST = 32'h0000_0002;
  localparam logic [GCTM_DUTY_W-1:0] GCTM_DUTY_FULL = 7'h64;
  localparam logic [GCTM_DUTY_W-1:0] GCTM_DUTY_RST = 7'h32;
  localparam int GCTM_CLK_MHZ = 20;

  typedef enum logic [2:0] {
    GCTM_EVENT = 3'h0,
    GCTM_UPDN = 3'h1,
    GCTM_MEAS = 3'h2,
    GCTM_RATE = 3'h3,
    GCTM_ONESHOT = 3'h4,
    GCTM_REPSHOT = 3'h5,
    GCTM_IDLE = 3'h6
  } gctm_mode_e;

  // Start/stop edge select
  typedef enum logic [1:0] {
    GCTM_GATE_RISE = 2'h0,
    GCTM_GATE_FALL = 2'h1,
    GCTM_CLK_RISE = 2'h2,
    GCTM_CLK_FALL = 2'h3
  } gctm_edge_e;

  typedef enum logic [1:0] {
    GCTM_ST_ARMED = 2'h0,
    GCTM_ST_RUN = 2'h1,
    GCTM_ST_DONE = 2'h2
  } gctm_state_e;
endpackage : gctm_pkg

// ==== core/gctm_channel.sv ====
// Purpose: One 32-bit general counter/timer channel with seven modes
// Assumes: Config is held stable while running; arm restarts a run
// Notes: External clock and gate are synchronised to clk first
`timescale 1ns/100ps
`default_nettype none

module gctm_channel
  import gctm_pkg::*;
(
  // System
  input wire logic clk,
  input wire logic rst,
  // Configuration
  input wire logic [2:0] mode,
  input wire logic clk_src_ext,
  input wire logic [31:0] clk_div,
  input wire logic gate_high,
  input wire logic gate_rise,
  input wire logic [1:0] start_edge,
  input wire logic [1:0] stop_edge,
  input wire logic pol_low_high,
  input wire logic [GCTM_DUTY_W-1:0] duty,
  input wire logic arm,
  input wire logic load,
  input wire logic [31:0] load_value,
  // Pins
  input wire logic ext_clk,
  input wire logic ext_gate,
  output logic pulse_out,
  // Status
  output logic [31:0] count,
  output logic busy
);
  logic [2:0] clk_sync_reg, clk_sync_next;
  logic [2:0] gate_sync_reg, gate_sync_next;
  logic [GCTM_W-1:0] cnt_reg, cnt_next;
  logic [31:0] div_reg, div_next;
  logic [31:0] per_reg, per_next;
  logic active_reg, active_next;
  gctm_state_e st_reg, st_next;
  logic c_rise, c_fall, g_rise, g_fall, g_lvl, gate_ok, tick;
  logic start_hit, stop_hit, trig, per_end, div_restart;
  logic [31:0] per_len, act_len;
  logic [38:0] act_prod;

  // Two stages then an edge stage; only stage 1 onward is read
  always_comb begin
    clk_sync_next = {clk_sync_reg[1:0], ext_clk};
    gate_sync_next = {gate_sync_reg[1:0], ext_gate};
  end
  assign c_rise = clk_sync_reg[1] & ~clk_sync_reg[2];
  assign c_fall = ~clk_sync_reg[1] & clk_sync_reg[2];
  assign g_rise = gate_sync_reg[1] & ~gate_sync_reg[2];
  assign g_fall = ~gate_sync_reg[1] & gate_sync_reg[2];
  assign g_lvl = gate_sync_reg[1];
  assign gate_ok = gate_high ? g_lvl : ~g_lvl;

  function automatic logic edge_sel(input logic [1:0] s, input logic gr,
      input logic gf, input logic cr, input logic cf);
    unique case (s)
      GCTM_GATE_RISE: edge_sel = gr;
      GCTM_GATE_FALL: edge_sel = gf;
      GCTM_CLK_RISE: edge_sel = cr;
      GCTM_CLK_FALL: edge_sel = cf;
    endcase
  endfunction : edge_sel

  assign start_hit = edge_sel(start_edge, g_rise, g_fall, c_rise, c_fall);
  assign stop_hit = edge_sel(stop_edge, g_rise, g_fall, c_rise, c_fall);
  assign trig = gate_rise ? g_rise : g_fall;
  // Restart the divider on a trigger so a shot holds whole ticks only
  assign div_restart = (mode == GCTM_ONESHOT || mode == GCTM_REPSHOT)
    && st_reg == GCTM_ST_ARMED && trig;

  // Timebase tick: divided clk or external rises; divider 0 acts as 1
  assign tick = clk_src_ext ? c_rise : (div_reg == 32'h0000_0000);
  always_comb begin
    div_next = div_reg;
    if (clk_src_ext || div_restart || div_reg == 32'h0000_0000) begin
      div_next = (clk_div > 32'h0000_0001) ? clk_div - 32'h0000_0001
                                         : 32'h0000_0000;
    end else begin
      div_next = div_reg - 32'h0000_0001;
    end
  end

  // Period of two ticks minimum keeps output at or below half clk
  assign per_len = (clk_div < 32'h0000_0002) ? 32'h0000_0002 : clk_div;
  assign act_prod = 39'(per_len) * 39'(duty);
  always_comb begin
    act_len = 32'(act_prod / 39'd100);
    if (mode == GCTM_ONESHOT || mode == GCTM_REPSHOT) begin
      act_len = per_len;
    end
    if (act_len == 32'h0000_0000) begin
      act_len = 32'h0000_0001;
    end
  end
  assign per_end = (per_reg == per_len - 32'h0000_0001);

  always_comb begin
    cnt_next = cnt_reg;
    per_next = per_reg;
    active_next = 1'b0;
    st_next = st_reg;
    unique case (mode)
      GCTM_EVENT: begin
        // Gate level, per gate_high, decides which external clock rises are counted
        if (c_rise && gate_ok) begin
          cnt_next = cnt_reg + 32'h0000_0001;
        end
      end
      GCTM_UPDN: begin
        if (c_rise) begin
          cnt_next = g_lvl ? cnt_reg + 32'h0000_0001
                           : cnt_reg - 32'h0000_0001;
        end
      end
      GCTM_MEAS: begin
        unique case (st_reg)
          GCTM_ST_ARMED: if (start_hit) begin
            st_next = GCTM_ST_RUN;
            cnt_next = GCTM_CNT_RST;
          end
          GCTM_ST_RUN: begin
            if (stop_hit) begin
              st_next = GCTM_ST_DONE;
            end else begin
              cnt_next = cnt_reg + 32'h0000_0001;
            end
          end
          default: st_next = GCTM_ST_DONE;
        endcase
      end
      GCTM_RATE: begin
        if (gate_ok) begin
          if (tick) begin
            per_next = per_end ? 32'h0000_0000 : per_reg + 32'h0000_0001;
          end
          active_next = (per_next < act_len);
        end else begin
          per_next = 32'h0000_0000;
        end
      end
      GCTM_ONESHOT, GCTM_REPSHOT: begin
        unique case (st_reg)
          GCTM_ST_ARMED: if (trig) begin
            st_next = GCTM_ST_RUN;
            per_next = 32'h0000_0000;
            active_next = 1'b1;
          end
          GCTM_ST_RUN: begin
            // Trigger not examined here, so edges mid-pulse are lost
            active_next = 1'b1;
            if (tick) begin
              per_next = per_reg + 32'h0000_0001;
              if (per_next >= act_len) begin
                active_next = 1'b0;
                st_next = (mode == GCTM_REPSHOT) ? GCTM_ST_ARMED
                                                 : GCTM_ST_DONE;
              end
            end
          end
          default: st_next = GCTM_ST_DONE;
        endcase
      end
      default: begin
        per_next = 32'h0000_0000;
      end
    endcase
    if (arm) begin
      st_next = GCTM_ST_ARMED;
      per_next = 32'h0000_0000;
      active_next = 1'b0;
    end
    if (load) begin
      cnt_next = load_value;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      clk_sync_reg <= 3'h0;
      gate_sync_reg <= 3'h0;
      cnt_reg <= GCTM_CNT_RST;
      div_reg <= GCTM_DIV_RST;
      per_reg <= 32'h0000_0000;
      active_reg <= 1'b0;
      st_reg <= GCTM_ST_DONE;
    end else begin
      clk_sync_reg <= clk_sync_next;
      gate_sync_reg <= gate_sync_next;
      cnt_reg <= cnt_next;
      div_reg <= div_next;
      per_reg <= per_next;
      active_reg <= active_next;
      st_reg <= st_next;
    end
  end

  // Active portion is low for high-to-low type
  always_ff @(posedge clk) begin
    if (rst) begin
      pulse_out <= 1'b0;
    end else begin
      pulse_out <= pol_low_high ? active_next : ~active_next;
    end
  end
  assign count = cnt_reg;
  assign busy = (st_reg == GCTM_ST_RUN);

  up_count_a: assert property (@(posedge clk) disable iff (rst)
    (mode == GCTM_EVENT && c_rise && gate_ok && !load)
      |=> count == $past(count) + 32'h0000_0001)
    else $error("event count missed an edge");
  gate_block_a: assert property (@(posedge clk) disable iff (rst)
    (mode == GCTM_EVENT && !gate_ok && !load) |=> $stable(count))
    else $error("event count moved with gate inactive");
  down_count_a: assert property (@(posedge clk) disable iff (rst)
    (mode == GCTM_UPDN && c_rise && !g_lvl && !load)
      |=> count == $past(count) - 32'h0000_0001)
    else $error("up/down did not decrement");
  meas_hold_a: assert property (@(posedge clk) disable iff (rst)
    (mode == GCTM_MEAS && st_reg == GCTM_ST_DONE && !arm && !load)
      |=> $stable(count) && st_reg == GCTM_ST_DONE)
    else $error("interval count moved after stop");
  meas_run_a: assert property (@(posedge clk) disable iff (rst)
    (mode == GCTM_MEAS && st_reg == GCTM_ST_RUN && !stop_hit && !arm
      && !load) |=> count == $past(count) + 32'h0000_0001)
    else $error("interval count not per clk");
  rate_stop_a: assert property (@(posedge clk) disable iff (rst)
    (mode == GCTM_RATE && !gate_ok && !arm)
      |=> pulse_out == !$past(pol_low_high))
    else $error("rate output not idle with gate off");
  shot_done_a: assert property (@(posedge clk) disable iff (rst)
    (mode == GCTM_ONESHOT && st_reg == GCTM_ST_DONE && !arm)
      |=> pulse_out == !$past(pol_low_high))
    else $error("one-shot fired after completion");
  shot_start_a: assert property (@(posedge clk) disable iff (rst)
    (mode == GCTM_ONESHOT && st_reg == GCTM_ST_ARMED && trig && !arm)
      |=> pulse_out == $past(pol_low_high) && busy)
    else $error("one-shot did not start on edge");
  rep_ignore_a: assert property (@(posedge clk) disable iff (rst)
    (mode == GCTM_REPSHOT && st_reg == GCTM_ST_RUN && trig && !tick && !arm)
      |=> st_reg == GCTM_ST_RUN)
    else $error("repetitive pulse retriggered");
  up_step_a: assert property (@(posedge clk) disable iff (rst)
    (mode == GCTM_UPDN && c_rise && g_lvl && !load)
      |=> count == $past(count) + 32'h0000_0001)
    else $error("up/down did not increment");
  wrap_zero_a: assert property (@(posedge clk) disable iff (rst)
    (mode == GCTM_EVENT && c_rise && gate_ok && !load
      && count == 32'hFFFF_FFFF) |=> count == 32'h0000_0000)
    else $error("event count did not wrap to zero");
  load_take_a: assert property (@(posedge clk) disable iff (rst)
    load |=> count == $past(load_value))
    else $error("load value not taken");
  arm_idle_a: assert property (@(posedge clk) disable iff (rst)
    arm |=> !busy && pulse_out == !$past(pol_low_high))
    else $error("arm did not idle the channel");
  rep_start_a: assert property (@(posedge clk) disable iff (rst)
    (mode == GCTM_REPSHOT && st_reg == GCTM_ST_ARMED && trig && !arm)
      |=> busy && pulse_out == $past(pol_low_high))
    else $error("repetitive pulse did not start on edge");

  rate_run_c: cover property (@(posedge clk) disable iff (rst)
    mode == GCTM_RATE && gate_ok ##1 $changed(pulse_out));
  shot_c: cover property (@(posedge clk) disable iff (rst)
    mode == GCTM_ONESHOT && busy ##1 !busy);
  meas_c: cover property (@(posedge clk) disable iff (rst)
    mode == GCTM_MEAS && st_reg == GCTM_ST_RUN && stop_hit);
  wrap_c: cover property (@(posedge clk) disable iff (rst)
    count == 32'hFFFF_FFFF ##1 count == 32'h0000_0000);
  rep_c: cover property (@(posedge clk) disable iff (rst)
    mode == GCTM_REPSHOT && busy ##1 !busy);
endmodule : gctm_channel

`default_nettype wire

// ==== test/gctm_src.sv ====
// Purpose: Model of the outside world: pulse source and gate driver
// Assumes: Pins move on the falling edge of the system clock
// Notes: Source clock idles low between bursts, 5 MHz within a burst
`timescale 1ns/100ps
`default_nettype none
module gctm_src (
  // Timing
  input wire logic clk,
  // Pins
  output logic ext_clk,
  output logic ext_gate
);
  initial begin
    ext_clk = 1'b0;
    ext_gate = 1'b0;
  end

  // Two clk per half period, so the 2-stage sync never misses an edge
  task automatic burst(input int n);
    repeat (n) begin
      @(negedge clk);
      ext_clk = 1'b1;
      repeat (2) @(negedge clk);
      ext_clk = 1'b0;
      @(negedge clk);
    end
  endtask : burst

  // Trailing wait lets the synchronised level land before the next step
  task automatic gate(input logic v, input int w);
    @(negedge clk);
    ext_gate = v;
    repeat (w) @(negedge clk);
  endtask : gate
endmodule : gctm_src
`default_nettype wire

// ==== test/tb_general_counter_timer_modes.sv ====
// Purpose: Self-checking bench for the counter/timer channel
// Assumes: Inputs move on the falling edge; pin model in gctm_src
// Notes: Pulse lengths judged by counting active cycles in a window
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value at %0t: got %0h exp %0h", $time, g, e); end end
module tb_general_counter_timer_modes
  import gctm_pkg::*;
;
  logic clk, rst, clk_src_ext, gate_high, gate_rise, pol_low_high;
  logic arm, load, pulse_out, busy, prev_act;
  logic [2:0] mode;
  logic [31:0] clk_div, load_value, count, ca, cb;
  logic [1:0] start_edge, stop_edge;
  logic [GCTM_DUTY_W-1:0] duty;
  wire ext_clk, ext_gate;
  int error_cnt, n_tests, cyc, act_n, rise_n;

  gctm_channel dut (.clk(clk), .rst(rst), .mode(mode),
    .clk_src_ext(clk_src_ext), .clk_div(clk_div), .gate_high(gate_high),
    .gate_rise(gate_rise), .start_edge(start_edge), .stop_edge(stop_edge),
    .pol_low_high(pol_low_high), .duty(duty), .arm(arm), .load(load),
    .load_value(load_value), .ext_clk(ext_clk), .ext_gate(ext_gate),
    .pulse_out(pulse_out), .count(count), .busy(busy));
  gctm_src src (.clk(clk), .ext_clk(ext_clk), .ext_gate(ext_gate));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Active level follows the polarity setting
  always @(posedge clk) begin
    cyc++;
    if (pulse_out === pol_low_high && prev_act !== 1'b1) rise_n++;
    if (pulse_out === pol_low_high) act_n++;
    prev_act = (pulse_out === pol_low_high);
    if (cyc > 20000) begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask : wt

  task automatic win(input int n);
    act_n = 0;
    rise_n = 0;
    wt(n);
  endtask : win

  task automatic strobe(input logic is_load, input logic [31:0] v);
    @(negedge clk);
    load_value = v;
    if (is_load) load = 1'b1;
    else arm = 1'b1;
    @(negedge clk);
    load = 1'b0;
    arm = 1'b0;
  endtask : strobe

  task automatic t_event();
    mode = GCTM_EVENT;
    clk_src_ext = 1'b1;
    gate_high = 1'b1;
    strobe(1'b1, 32'h0000_0000);
    src.gate(1'b1, 4);
    src.burst(5);
    wt(6);
    `CHK(count, 32'h0000_0005)
    src.gate(1'b0, 4);
    src.burst(3);
    wt(6);
    `CHK(count, 32'h0000_0005)
    gate_high = 1'b0;
    src.burst(2);
    wt(6);
    `CHK(count, 32'h0000_0007)
    strobe(1'b1, 32'hFFFF_FFFE);
    src.burst(3);
    wt(6);
    `CHK(count, 32'h0000_0001)
  endtask : t_event

  // Gate type and internal source set so that obeying them would show
  task automatic t_updn();
    mode = GCTM_UPDN;
    clk_src_ext = 1'b0;
    strobe(1'b1, 32'h0000_000A);
    src.gate(1'b1, 4);
    src.burst(4);
    wt(6);
    `CHK(count, 32'h0000_000E)
    src.gate(1'b0, 4);
    src.burst(6);
    wt(6);
    `CHK(count, 32'h0000_0008)
    mode = GCTM_IDLE;
    src.burst(2);
    wt(6);
    `CHK(count, 32'h0000_0008)
    `CHK(pulse_out, 1'b1)
  endtask : t_updn

  task automatic t_interval();
    mode = GCTM_MEAS;
    start_edge = GCTM_GATE_RISE;
    stop_edge = GCTM_GATE_FALL;
    strobe(1'b0, 32'h0000_0000);
    src.gate(1'b1, 4);
    wt(10);
    `CHK(busy, 1'b1)
    src.gate(1'b0, 8);
    ca = count;
    `CHK(busy, 1'b0)
    src.gate(1'b1, 6);
    src.gate(1'b0, 6);
    `CHK(count, ca)
    start_edge = GCTM_GATE_FALL;
    stop_edge = GCTM_GATE_RISE;
    strobe(1'b0, 32'h0000_0000);
    src.gate(1'b1, 6);
    src.gate(1'b0, 4);
    wt(40);
    src.gate(1'b1, 8);
    cb = count;
    `CHK(cb - ca, 32'h0000_001E)
    start_edge = GCTM_CLK_RISE;
    stop_edge = GCTM_CLK_FALL;
    strobe(1'b0, 32'h0000_0000);
    src.burst(1);
    wt(8);
    `CHK(count, ca - 32'h0000_000D)
  endtask : t_interval

  task automatic t_rate();
    mode = GCTM_RATE;
    clk_src_ext = 1'b0;
    clk_div = 32'h0000_0004;
    duty = 7'h19;
    pol_low_high = 1'b1;
    gate_high = 1'b1;
    src.gate(1'b0, 20);
    win(80);
    `CHK(act_n, 0)
    src.gate(1'b1, 20);
    win(80);
    `CHK(act_n, 20)
    pol_low_high = 1'b0;
    duty = 7'h32;
    gate_high = 1'b0;
    src.gate(1'b0, 20);
    win(80);
    `CHK(act_n, 40)
    src.gate(1'b1, 20);
    win(40);
    `CHK(act_n, 0)
    clk_src_ext = 1'b1;
    clk_div = 32'h0000_0002;
    gate_high = 1'b1;
    win(4);
    src.burst(8);
    wt(4);
    `CHK(rise_n, 5)
  endtask : t_rate

  // Both trigger edges and both polarities, duty set low on purpose
  task automatic t_oneshot();
    for (int p = 0; p < 2; p++) begin
      mode = GCTM_ONESHOT;
      clk_src_ext = 1'b0;
      clk_div = 32'h0000_0001;
      duty = 7'h0A;
      pol_low_high = p[0];
      gate_rise = p[0];
      src.gate(~p[0], 6);
      strobe(1'b0, 32'h0000_0000);
      act_n = 0;
      rise_n = 0;
      src.gate(p[0], 30);
      `CHK(rise_n, 1)
      `CHK(act_n, 2)
      src.gate(~p[0], 6);
      src.gate(p[0], 20);
      `CHK(rise_n, 1)
      `CHK(busy, 1'b0)
    end
  endtask : t_oneshot

  task automatic t_repeat();
    mode = GCTM_REPSHOT;
    clk_div = 32'h0000_0008;
    pol_low_high = 1'b1;
    gate_rise = 1'b1;
    src.gate(1'b0, 6);
    strobe(1'b0, 32'h0000_0000);
    act_n = 0;
    rise_n = 0;
    src.gate(1'b1, 0);
    src.gate(1'b0, 0);
    src.gate(1'b1, 100);
    src.gate(1'b0, 4);
    src.gate(1'b1, 100);
    `CHK(rise_n, 2)
    `CHK(act_n, 128)
  endtask : t_repeat

  task automatic finish_test();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  initial begin
    rst = 1'b1;
    arm = 1'b0;
    load = 1'b0;
    clk_src_ext = 1'b0;
    gate_high = 1'b0;
    gate_rise = 1'b0;
    pol_low_high = 1'b0;
    mode = GCTM_EVENT;
    start_edge = GCTM_CLK_FALL;
    stop_edge = GCTM_GATE_RISE;
    clk_div = 32'h0000_0002;
    load_value = 32'h0000_0000;
    duty = 7'h32;
    wt(6);
    rst = 1'b0;
    t_event();
    t_updn();
    t_interval();
    t_rate();
    t_oneshot();
    t_repeat();
    finish_test();
  end
endmodule : tb_general_counter_timer_modes
`default_nettype wire
